// ---- hw/dbgtrc_core.sv ----
// Debug trace, return and breakpoint control engine
//
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module dbgtrc_core
  import dbgtrc_pkg::*;
#(
  parameter int DATA_MEM_BYTES = 2048
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // External reset pin, asynchronous to clk
  input  wire logic        resetPin_n,
  // Register port
  input  wire logic [3:0]  regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output var  logic [15:0] regRdData,
  // Host command link, already decoded in clk domain
  input  wire logic        hostCmdValid,
  input  wire logic [3:0]  hostCmd,
  input  wire logic        xferEnd,
  input  wire logic        debugEnter,
  // CPU observation
  input  wire logic        cpuIge,
  input  wire logic        cpuUpa,
  input  wire logic [15:0] cpuIp,
  input  wire logic        cpuInstrDone,
  input  wire logic [7:0]  cpuDestAddr,
  input  wire logic [15:0] cpuDestData,
  input  wire logic        cpuDestWr,
  input  wire logic [15:0] stackTop,
  input  wire logic        stackFull,
  input  wire logic        ipInSysMem,
  input  wire logic        multiRegion,
  input  wire logic        divBy256,
  input  wire logic        warmupDone,
  input  wire logic [7:0]  pwByte,
  input  wire logic        pwByteValid,
  // CPU control
  output logic             cpuHalt,
  output logic             fetchBlock,
  output logic             ipLoad,
  output logic [15:0]      ipLoadValue,
  output logic             igeForce,
  output logic             igeValue,
  output logic             upaValue,
  output logic             stackPush,
  output logic             stackPop,
  output logic             stackOverwrite,
  output logic [15:0]      stackPushData,
  output logic             forceDivOne,
  output logic             clkSwitch,
  output logic             timersRun,
  output logic             sysClkGate,
  output logic             breakReq,
  output logic [1:0]       linkStatus,
  output logic             pwPresent,
  output logic [15:0]      workspaceBase
);

  // ----------------------------------------------------------------
  // Synchronised reset pin
  // ----------------------------------------------------------------
  logic pinLevel;

  dbgtrc_sync u_sync (
    .clk      (clk),
    .arst_n   (arst_n),
    .pinIn    (resetPin_n),
    .levelOut (pinLevel)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  dbgtrc_state_t state_r;
  dbgtrc_state_t state_nxt;
  logic [15:0]   scratch0_r;
  logic [15:0]   scratch1_r;
  logic [7:0]    control_r;
  logic          txc_r;
  logic [7:0]    byteBuf_r;
  logic [15:0]   dataMatch_r;
  logic [15:0]   addrMask_r;
  logic [7:0]    bpFour_r;
  logic [7:0]    bpFive_r;
  logic [15:0]   retAddr_r;
  logic          entryIge_r;
  logic          savedUpa_r;
  logic          skipBreak_r;
  logic          pinRst_r;

  logic inDebug;
  logic inBackground;
  logic cmdStart;

  assign inBackground = (state_r == DT_BACKGROUND);
  assign inDebug      = !inBackground;
  // Pin low acts as a synchronous engine reset
  assign pinRst_r     = !pinLevel;
  assign cmdStart     = hostCmdValid && (state_r == DT_IDLE);

  function automatic logic dataMatch(input logic [15:0] d, input logic [15:0] m,
                                     input logic [15:0] p);
    dataMatch = ((d ^ p) & m) == 16'h0000;
  endfunction

  function automatic logic regHit(input logic [3:0] a, input logic [3:0] ofs);
    regHit = (a == ofs);
  endfunction

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      DT_BACKGROUND: begin
        if (debugEnter) begin
          state_nxt = DT_IDLE;
        end
      end
      DT_IDLE: begin
        if (cmdStart && hostCmd == CMD_TRACE && !(ipInSysMem && multiRegion)) begin
          state_nxt = DT_TRC_POP;
        end else if (cmdStart && hostCmd == CMD_RETURN) begin
          state_nxt = DT_RET_POP;
        end
      end
      DT_TRC_POP:  state_nxt = DT_TRC_EXEC;
      DT_TRC_EXEC: begin
        if (cpuInstrDone) begin
          state_nxt = DT_TRC_PUSH;
        end
      end
      DT_TRC_PUSH: state_nxt = DT_IDLE;
      DT_RET_POP:  state_nxt = DT_RET_GO;
      DT_RET_GO:   state_nxt = DT_BACKGROUND;
      default:     state_nxt = DT_BACKGROUND;
    endcase
    if (pinRst_r) state_nxt = DT_BACKGROUND;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= DT_BACKGROUND;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Entry capture and return address
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      entryIge_r <= 1'b0;
      savedUpa_r <= 1'b0;
      retAddr_r  <= 16'h0000;
    end else if (inBackground && debugEnter) begin
      entryIge_r <= cpuIge;
      savedUpa_r <= cpuUpa;
      retAddr_r  <= cpuIp;
    end else if (state_r == DT_IDLE && state_nxt != DT_IDLE) begin
      retAddr_r <= stackTop;
    end else if (state_r == DT_TRC_EXEC && cpuInstrDone) begin
      retAddr_r  <= cpuIp;
      savedUpa_r <= cpuUpa;
    end
  end

  // ----------------------------------------------------------------
  // CPU control outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cpuHalt        <= 1'b0;
      fetchBlock     <= 1'b0;
      ipLoad         <= 1'b0;
      ipLoadValue    <= 16'h0000;
      igeForce       <= 1'b0;
      igeValue       <= 1'b0;
      upaValue       <= 1'b0;
      stackPush      <= 1'b0;
      stackPop       <= 1'b0;
      stackOverwrite <= 1'b0;
      stackPushData  <= 16'h0000;
    end else begin
      ipLoad    <= 1'b0;
      stackPush <= 1'b0;
      stackPop  <= 1'b0;
      case (state_nxt)
        DT_IDLE: begin
          cpuHalt    <= 1'b1;
          fetchBlock <= 1'b1;
          igeForce   <= 1'b1;
          igeValue   <= 1'b0;
          upaValue   <= 1'b0;
          if (state_r == DT_BACKGROUND || state_r == DT_TRC_PUSH) begin
            stackPush      <= 1'b1;
            stackOverwrite <= stackFull;
            stackPushData  <= (state_r == DT_TRC_PUSH) ? retAddr_r : cpuIp;
            ipLoad         <= 1'b1;
            ipLoadValue    <= SERVICE_VECTOR;
          end
        end
        DT_TRC_POP, DT_RET_POP: begin
          stackPop <= (state_r == DT_IDLE);
        end
        DT_TRC_EXEC: begin
          cpuHalt    <= 1'b0;
          fetchBlock <= cpuInstrDone || (state_r == DT_TRC_EXEC && cpuHalt);
          igeValue   <= entryIge_r;
          upaValue   <= savedUpa_r;
          if (state_r == DT_TRC_POP) begin
            ipLoad      <= 1'b1;
            ipLoadValue <= retAddr_r;
          end
        end
        DT_RET_GO: begin
          ipLoad      <= 1'b1;
          ipLoadValue <= retAddr_r;
          upaValue    <= savedUpa_r;
          igeValue    <= entryIge_r;
        end
        DT_BACKGROUND: begin
          cpuHalt    <= 1'b0;
          fetchBlock <= 1'b0;
          igeForce   <= 1'b0;
        end
        default: begin
          cpuHalt <= 1'b1;
        end
      endcase
      if (pinRst_r) begin
        cpuHalt  <= 1'b0;
        igeForce <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Link status and clocking
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      linkStatus <= ST_NONDEBUG;
      timersRun  <= 1'b1;
      sysClkGate <= 1'b1;
      forceDivOne <= 1'b0;
      clkSwitch  <= 1'b0;
    end else begin
      case (state_nxt)
        DT_BACKGROUND: linkStatus <= ST_NONDEBUG;
        DT_IDLE:       linkStatus <= txc_r ? ST_VALID : ST_IDLE;
        default:       linkStatus <= ST_BUSY;
      endcase
      timersRun  <= (state_nxt == DT_BACKGROUND);
      // Clock stops only in idle with no command pending and the transfer flag clear
      sysClkGate <= (state_nxt != DT_IDLE) || hostCmdValid || txc_r;
      if (inBackground && debugEnter && control_r[CTL_SWB_BIT] && divBy256) begin
        forceDivOne <= 1'b1;
      end else if (state_nxt == DT_BACKGROUND) begin
        forceDivOne <= 1'b0;
      end
      clkSwitch <= warmupDone;
    end
  end

  // ----------------------------------------------------------------
  // Breakpoints
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      skipBreak_r <= 1'b0;
      breakReq    <= 1'b0;
    end else begin
      if (state_r == DT_RET_GO) begin
        skipBreak_r <= 1'b1;
      end else if (cpuInstrDone) begin
        skipBreak_r <= 1'b0;
      end
      breakReq <= 1'b0;
      if (inBackground && !skipBreak_r && control_r[CTL_BRK_EN_BIT] && cpuDestWr
          && control_r[CTL_REG_SEL_BIT]) begin
        if (cpuDestAddr == bpFour_r) begin
          breakReq <= 1'b1;
        end
        if (cpuDestAddr == bpFive_r && dataMatch(cpuDestData, addrMask_r, dataMatch_r)) begin
          breakReq <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Password presence
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pwPresent <= 1'b0;
    end else if (pwByteValid && pwByte != PW_BLANK_HI && pwByte != PW_BLANK_LO) begin
      pwPresent <= 1'b1;
    end
  end

  // Workspace is the top bytes of data memory
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      workspaceBase <= 16'h0000;
    end else begin
      workspaceBase <= 16'(DATA_MEM_BYTES - WORKSPACE_BYTES);
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scratch0_r  <= SCRATCH_RST;
      scratch1_r  <= SCRATCH_RST;
      control_r   <= CONTROL_RST;
      byteBuf_r   <= 8'h00;
      dataMatch_r <= 16'h0000;
      addrMask_r  <= 16'h0000;
      bpFour_r    <= 8'h00;
      bpFive_r    <= 8'h00;
    end else begin
      if (regWr && regHit(regAddr, OFS_SCRATCH_ZERO)) begin
        scratch0_r <= regWrData;
      end
      if (regWr && regHit(regAddr, OFS_SCRATCH_ONE)) begin
        scratch1_r <= regWrData;
      end
      if (regWr && regHit(regAddr, OFS_CONTROL) && inBackground) begin
        control_r[7:4] <= regWrData[7:4];
      end
      if (cmdStart) begin
        control_r[3:0] <= (hostCmd == CMD_TRACE || hostCmd == CMD_RETURN) ? CMD_NOP : hostCmd;
      end
      if (regWr && regHit(regAddr, OFS_BYTE_BUFFER)) byteBuf_r <= regWrData[7:0];
      if (regWr && regHit(regAddr, OFS_DATA_MATCH))  dataMatch_r <= regWrData;
      if (regWr && regHit(regAddr, OFS_ADDR_MASK))   addrMask_r <= regWrData;
      if (regWr && regHit(regAddr, OFS_BREAK_FOUR))  bpFour_r <= regWrData[7:0];
      if (regWr && regHit(regAddr, OFS_BREAK_FIVE))  bpFive_r <= regWrData[7:0];
    end
  end

  // Transfer complete: software sets, engine clears at transfer end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      txc_r <= 1'b0;
    end else if (regWr && regHit(regAddr, OFS_FLAGS) && regWrData[FLG_TXC_BIT]) begin
      txc_r <= 1'b1;
    end else if (xferEnd) begin
      txc_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdData <= 16'h0000;
    end else begin
      regRdData <= 16'h0000;
      if (regRd) begin
        case (regAddr)
          OFS_SCRATCH_ZERO: regRdData <= scratch0_r;
          OFS_SCRATCH_ONE:  regRdData <= scratch1_r;
          OFS_CONTROL:      regRdData <= {8'h00, control_r};
          OFS_FLAGS:        regRdData <= {15'h0000, txc_r};
          OFS_BYTE_BUFFER:  regRdData <= {8'h00, byteBuf_r};
          OFS_DATA_MATCH:   regRdData <= dataMatch_r;
          OFS_ADDR_MASK:    regRdData <= addrMask_r;
          OFS_BREAK_FOUR:   regRdData <= {8'h00, bpFour_r};
          OFS_BREAK_FIVE:   regRdData <= {8'h00, bpFive_r};
          OFS_STATUS:       regRdData <= {14'h0000, linkStatus};
          default:          regRdData <= 16'h0000;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ---- hw/dbgtrc_pkg.sv ----
// Package with constants for the debug trace and return control block
package dbgtrc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_SCRATCH_ZERO = 4'h0;
  localparam logic [3:0] OFS_SCRATCH_ONE  = 4'h1;
  localparam logic [3:0] OFS_CONTROL      = 4'h2;
  localparam logic [3:0] OFS_FLAGS        = 4'h3;
  localparam logic [3:0] OFS_BYTE_BUFFER  = 4'h4;
  localparam logic [3:0] OFS_DATA_MATCH   = 4'h5;
  localparam logic [3:0] OFS_ADDR_MASK    = 4'h6;
  localparam logic [3:0] OFS_BREAK_FOUR   = 4'h7;
  localparam logic [3:0] OFS_BREAK_FIVE   = 4'h8;
  localparam logic [3:0] OFS_STATUS       = 4'h9;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTL_BRK_EN_BIT  = 7;
  localparam int CTL_REG_SEL_BIT = 5;
  localparam int CTL_SWB_BIT     = 4;
  localparam int FLG_TXC_BIT     = 0;

  // ----------------------------------------------------------------
  // Reset values and fixed figures
  // ----------------------------------------------------------------
  localparam logic [15:0] SCRATCH_RST     = 16'h0000;
  localparam logic [7:0]  CONTROL_RST     = 8'h00;
  localparam logic [15:0] SERVICE_VECTOR  = 16'h8010;
  localparam logic [15:0] PASSWORD_WORD   = 16'h2010;
  localparam logic [7:0]  PW_BLANK_HI     = 8'hFF;
  localparam logic [7:0]  PW_BLANK_LO     = 8'h00;
  localparam int          WORKSPACE_BYTES = 32;

  // ----------------------------------------------------------------
  // Link status codes
  // ----------------------------------------------------------------
  localparam logic [1:0] ST_NONDEBUG = 2'h0;
  localparam logic [1:0] ST_IDLE     = 2'h1;
  localparam logic [1:0] ST_BUSY     = 2'h2;
  localparam logic [1:0] ST_VALID    = 2'h3;

  // ----------------------------------------------------------------
  // Host command codes
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_NOP       = 4'h0;
  localparam logic [3:0] CMD_RD_MAP    = 4'h1;
  localparam logic [3:0] CMD_RD_DATA   = 4'h2;
  localparam logic [3:0] CMD_RD_STACK  = 4'h3;
  localparam logic [3:0] CMD_WR_REG    = 4'h4;
  localparam logic [3:0] CMD_WR_DATA   = 4'h5;
  localparam logic [3:0] CMD_TRACE     = 4'h6;
  localparam logic [3:0] CMD_RETURN    = 4'h7;
  localparam logic [3:0] CMD_UNLOCK    = 4'h8;
  localparam logic [3:0] CMD_RD_REG    = 4'h9;

  typedef enum {
    DT_BACKGROUND, DT_IDLE, DT_TRC_POP, DT_TRC_EXEC, DT_TRC_PUSH, DT_RET_POP, DT_RET_GO
  } dbgtrc_state_t;

endpackage

// ---- hw/dbgtrc_sync.sv ----
// Three-stage synchroniser that filters a pin level
`timescale 1ns/1ns
`default_nettype none
module dbgtrc_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // Pin and filtered level
  input  wire logic pinIn,
  output var  logic levelOut
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
    end else begin
      s1_r <= pinIn;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Change counts once stages two and three agree
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      levelOut <= 1'b1;
    end else if (s2_r == s3_r) begin
      levelOut <= s3_r;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/dbgtrc_core_assertions.sv ----
// Concurrent checks on the ports of the debug trace and return engine
`timescale 1ns/1ns
`default_nettype none
module dbgtrc_core_assertions
  import dbgtrc_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        arst_n,
  // Requests and CPU levels
  input wire logic        hostCmdValid,
  input wire logic [3:0]  hostCmd,
  input wire logic        regRd,
  input wire logic        ipInSysMem,
  input wire logic        multiRegion,
  input wire logic        cpuInstrDone,
  input wire logic [15:0] cpuIp,
  input wire logic [7:0]  pwByte,
  input wire logic        pwByteValid,
  // Engine outputs
  input wire logic        cpuHalt,
  input wire logic        ipLoad,
  input wire logic [15:0] ipLoadValue,
  input wire logic        stackPush,
  input wire logic        stackPop,
  input wire logic [15:0] stackPushData,
  input wire logic        timersRun,
  input wire logic        igeForce,
  input wire logic [1:0]  linkStatus,
  input wire logic        pwPresent,
  input wire logic [15:0] regRdData
);
  // ------------------------------------------------------------
  // Helper terms
  // ------------------------------------------------------------
  logic trcGo;
  logic retGo;
  logic lockOut;
  logic stepDone;
  assign trcGo    = hostCmdValid && hostCmd == CMD_TRACE && linkStatus == ST_IDLE;
  assign retGo    = hostCmdValid && hostCmd == CMD_RETURN && linkStatus == ST_IDLE;
  assign lockOut  = ipInSysMem && multiRegion;
  assign stepDone = linkStatus == ST_BUSY && !cpuHalt && cpuInstrDone;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  trace_busy_a: assert property (trcGo && !lockOut |=> linkStatus == ST_BUSY && stackPop)
    else $error("trace did not report busy and pop");
  trace_fetch_a: assert property (trcGo && !lockOut |=> ##1 ipLoad && !cpuHalt)
    else $error("trace did not release the cpu at the return address");
  trace_vector_a: assert property (stepDone |=> ##1
    ipLoad && ipLoadValue == SERVICE_VECTOR && cpuHalt && linkStatus == ST_IDLE)
    else $error("trace end did not vector, halt and go idle");
  trace_next_a: assert property (stepDone |=>
    ##1 stackPush && stackPushData == $past(cpuIp, 2))
    else $error("trace pushed a stale return address");
  trace_refuse_a: assert property (trcGo && lockOut |=> linkStatus == ST_IDLE && !stackPop)
    else $error("locked trace was not refused");
  return_seq_a: assert property (retGo |=> stackPop ##1 ipLoad
    ##1 linkStatus == ST_NONDEBUG && timersRun && !igeForce)
    else $error("return sequence out of order");
  read_quiet_a: assert property (!$past(regRd) |-> regRdData == 16'h0000)
    else $error("read data outside its cycle");
  pw_seen_a: assert property (pwByteValid && pwByte != PW_BLANK_HI && pwByte != PW_BLANK_LO
    |-> ##[1:2] pwPresent)
    else $error("programmed password byte not seen");
  pw_hold_a: assert property (pwPresent |=> pwPresent)
    else $error("password presence dropped");
  cover property (trcGo && !lockOut ##1 linkStatus == ST_BUSY);
  cover property (trcGo && lockOut);
  cover property (retGo);
endmodule
`default_nettype wire

// ---- testbench/dbgtrc_core_tb.sv ----
// Self-checking bench for the debug trace and return engine
`timescale 1ns/1ns
`default_nettype none
module dbgtrc_core_tb;
  import dbgtrc_pkg::*;
  // ------------------------------------------------------------
  // Signals and tables
  // ------------------------------------------------------------
  logic        clk = 1'h0;
  logic        arst_n = 1'h0;
  logic        resetPin_n = 1'h1;
  logic        regWr, regRd, hostCmdValid, xferEnd, debugEnter, wrArm, seen;
  logic        cpuIge, cpuUpa, ipInSysMem, multiRegion, divBy256, warmupDone;
  logic        pwByteValid, stackFull, cpuInstrDone, cpuDestWr, cpuHalt, ipLoad;
  logic        igeForce, igeValue, stackPush, stackPop, stackOverwrite, forceDivOne;
  logic        timersRun, breakReq, pwPresent, clkSwitch, sysClkGate;
  logic        sawOvr = 1'h0;
  logic [1:0]  linkStatus;
  logic [3:0]  regAddr, hostCmd, gap;
  logic [7:0]  cpuDestAddr, pwByte;
  logic [15:0] regWrData, regRdData, stackTop, cpuDestData, cpuIp, ipLoadValue;
  logic [15:0] stackPushData, d, workspaceBase;
  int          nMismatch = 0;
  int          comparisons = 0;
  localparam logic [35:0] ROWS [9] = '{
    {OFS_SCRATCH_ZERO, 16'hA5C3, 16'hA5C3}, {OFS_SCRATCH_ONE, 16'h3C5A, 16'h3C5A},
    {OFS_CONTROL, 16'h00B0, 16'h00B0}, {OFS_DATA_MATCH, 16'h1234, 16'h1234},
    {OFS_ADDR_MASK, 16'h0000, 16'h0000}, {OFS_BREAK_FOUR, 16'h0033, 16'h0033},
    {OFS_BREAK_FIVE, 16'h0022, 16'h0022}, {OFS_STATUS, 16'h0003, 16'h0000},
    {4'hF, 16'hBEEF, 16'h0000}};
  localparam logic [3:0] CODES [8] = '{CMD_NOP, CMD_RD_MAP, CMD_RD_DATA, CMD_RD_STACK,
    CMD_WR_REG, CMD_WR_DATA, CMD_UNLOCK, CMD_RD_REG};
  localparam logic [3:0]  GAPS [2] = '{4'h0, 4'h5};
  localparam logic [15:0] RETS [2] = '{16'h0100, 16'h0231};

  always #5 clk = ~clk;
  always @(posedge clk) if (stackOverwrite === 1'h1) sawOvr <= 1'h1;

  dbgtrc_core dut (.*, .fetchBlock(), .upaValue());
  dbgtrc_cpu_model cpu (.*);
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'h1) begin
      nMismatch++;
      $display("MISMATCH at %0t: %s", $time, m);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    regAddr   <= a;
    regWrData <= v;
    regWr     <= 1'h1;
    @(posedge clk);
    regWr <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'h1;
    @(posedge clk);
    regRd <= 1'h0;
    #1;
    d = regRdData;
  endtask
  task automatic cmd(input logic [3:0] c);
    @(posedge clk);
    hostCmd      <= c;
    hostCmdValid <= 1'h1;
    @(posedge clk);
    hostCmdValid <= 1'h0;
    #1;
  endtask
  task automatic enter();
    @(posedge clk);
    debugEnter <= 1'h1;
    @(posedge clk);
    debugEnter <= 1'h0;
  endtask
  function automatic logic hit(input int k);
    case (k)
      0: return linkStatus === ST_IDLE;
      1: return linkStatus === ST_NONDEBUG;
      2: return ipLoad === 1'h1 && ipLoadValue === SERVICE_VECTOR;
      default: return forceDivOne === 1'h1;
    endcase
  endfunction
  task automatic wt(input int k);
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      #1;
      if (hit(k)) return;
    end
    chk(1'h0, "wait ran out");
  endtask
  task automatic brk(input logic [7:0] a, input logic [15:0] v, input logic e);
    seen = 1'h0;
    @(posedge clk);
    cpuDestAddr <= a;
    cpuDestData <= v;
    wrArm       <= 1'h1;
    repeat (12) begin
      @(posedge clk);
      #1;
      seen |= breakReq;
    end
    @(posedge clk);
    wrArm <= 1'h0;
    repeat (3) @(posedge clk);
    chk(seen === e, "breakpoint outcome");
  endtask
  task automatic print_verdict();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, nMismatch);
    if (nMismatch == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    {regWr, regRd, hostCmdValid, xferEnd, debugEnter, wrArm, cpuIge, cpuUpa} = '0;
    {ipInSysMem, multiRegion, divBy256, warmupDone, pwByteValid, stackFull} = '0;
    {regAddr, hostCmd, regWrData, stackTop, cpuDestData, cpuDestAddr, pwByte} = '0;
    gap = 4'h2;
    repeat (10) @(posedge clk);
    arst_n <= 1'h1;
    rd(OFS_SCRATCH_ZERO);
    chk(d === SCRATCH_RST && timersRun === 1'h1, "reset state");
    chk(workspaceBase === 16'h07E0, "workspace base");
    foreach (ROWS[i]) begin
      wr(ROWS[i][35:32], ROWS[i][31:16]);
      rd(ROWS[i][35:32]);
      chk(d === ROWS[i][15:0], "register row");
    end
    $display("Test registers ended");
    brk(8'h22, 16'hBEEF, 1'h1);
    brk(8'h33, 16'h0000, 1'h1);
    wr(OFS_ADDR_MASK, 16'hFFFF);
    brk(8'h22, 16'h4321, 1'h0);
    brk(8'h22, 16'h1234, 1'h1);
    wr(OFS_FLAGS, 16'h0001);
    @(posedge clk);
    xferEnd <= 1'h1;
    @(posedge clk);
    xferEnd <= 1'h0;
    rd(OFS_FLAGS);
    chk(d === 16'h0000, "transfer flag");
    $display("Test breakpoints and flags ended");
    @(posedge clk);
    divBy256  <= 1'h1;
    stackFull <= 1'h1;
    cpuIge    <= 1'h1;
    warmupDone <= 1'h1;
    enter();
    wt(3);
    chk(sawOvr === 1'h1 && sysClkGate === 1'h0 && clkSwitch === 1'h1, "entry");
    wt(0);
    divBy256  <= 1'h0;
    stackFull <= 1'h0;
    wr(OFS_CONTROL, 16'h0000);
    rd(OFS_CONTROL);
    chk(d[7:4] === 4'hB, "control held in debug");
    foreach (CODES[i]) begin
      cmd(CODES[i]);
      repeat (2) @(posedge clk);
      rd(OFS_CONTROL);
      chk(d[3:0] === CODES[i], "command code");
    end
    foreach (GAPS[i]) begin
      @(posedge clk);
      gap      <= GAPS[i];
      stackTop <= RETS[i];
      cmd(CMD_TRACE);
      chk(linkStatus === ST_BUSY && stackPop === 1'h1, "trace busy");
      @(posedge clk);
      #1;
      chk(ipLoad === 1'h1 && ipLoadValue === RETS[i] && igeValue === 1'h1, "fetch");
      wt(2);
      chk(stackPush === 1'h1 && stackPushData === RETS[i] + 16'h0001, "trace end");
    end
    @(posedge clk);
    ipInSysMem  <= 1'h1;
    multiRegion <= 1'h1;
    cmd(CMD_TRACE);
    repeat (2) @(posedge clk);
    #1;
    chk(linkStatus === ST_IDLE && ipLoad === 1'h0, "locked trace");
    @(posedge clk);
    ipInSysMem  <= 1'h0;
    multiRegion <= 1'h0;
    stackTop    <= 16'h0420;
    cmd(CMD_RETURN);
    @(posedge clk);
    #1;
    chk(ipLoad === 1'h1 && ipLoadValue === 16'h0420, "return target");
    wt(1);
    chk(timersRun === 1'h1 && cpuHalt === 1'h0, "resumed");
    $display("Test trace and return ended");
    enter();
    wt(0);
    resetPin_n <= 1'h0;
    wt(1);
    resetPin_n <= 1'h1;
    @(posedge clk);
    pwByte      <= PW_BLANK_LO;
    pwByteValid <= 1'h1;
    @(posedge clk);
    pwByte <= PW_BLANK_HI;
    @(posedge clk);
    pwByte <= 8'h5A;
    #1;
    chk(pwPresent === 1'h0, "blank password");
    @(posedge clk);
    pwByteValid <= 1'h0;
    repeat (2) @(posedge clk);
    #1;
    chk(pwPresent === 1'h1, "password present");
    $display("Test special cases ended");
    print_verdict();
  end
  initial begin
    #400000;
    chk(1'h0, "run limit reached");
    print_verdict();
  end
endmodule

bind dbgtrc_core dbgtrc_core_assertions chk_u (.*);
`default_nettype wire

// ---- testbench/dbgtrc_cpu_model.sv ----
// CPU stand-in that executes one instruction per paced interval
`timescale 1ns/1ns
`default_nettype none
module dbgtrc_cpu_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Engine control
  input  wire logic        cpuHalt,
  input  wire logic        ipLoad,
  input  wire logic [15:0] ipLoadValue,
  // Pacing and destination write arming
  input  wire logic [3:0]  gap,
  input  wire logic        wrArm,
  // CPU observation
  output logic             cpuInstrDone,
  output logic [15:0]      cpuIp,
  output logic             cpuDestWr
);
  // ------------------------------------------------------------
  // Execution pacing
  // ------------------------------------------------------------
  logic [3:0] wait_r;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cpuInstrDone <= 1'h0;
      cpuIp        <= 16'h0000;
      wait_r       <= 4'h0;
    end else if (ipLoad) begin
      cpuInstrDone <= 1'h0;
      cpuIp        <= ipLoadValue;
      wait_r       <= gap;
    end else if (cpuHalt || wait_r != 4'h0) begin
      cpuInstrDone <= 1'h0;
      wait_r       <= cpuHalt ? wait_r : wait_r - 4'h1;
    end else begin
      cpuInstrDone <= 1'h1;
      cpuIp        <= cpuIp + 16'h0001;
      wait_r       <= gap;
    end
  end
  assign cpuDestWr = cpuInstrDone & wrArm;
endmodule
`default_nettype wire
